// File: rtl/fmtw_pkg.sv
// Purpose: Shared constants and types of the fault and thermal monitor.
// Assumes: 125 MHz system clock.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package fmtw_pkg;
   // =========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned WARMUP_MS     = 2;
   localparam int unsigned CONV_RATE_HZ  = 10;
   localparam int unsigned BOOST_OCP_MS  = 1600;
   localparam int unsigned VIN_OCP_US    = 10;
   localparam int unsigned WARMUP_CYC    = (CLK_HZ / 1000) * WARMUP_MS;
   localparam int unsigned PERIOD_CYC    = CLK_HZ / CONV_RATE_HZ;
   localparam int unsigned BOOST_OCP_CYC = (CLK_HZ / 1000) * BOOST_OCP_MS;
   localparam int unsigned VIN_OCP_CYC   =
      (VIN_OCP_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int unsigned TMR_W         = 28;
   localparam int unsigned VOCP_W        = 11;

   // =========================================================
   // Sizes and constants
   localparam int unsigned NCH           = 6;
   localparam int unsigned TEMP_W        = 9;
   localparam logic [8:0]  TEMP_OFF_VAL  = 9'h100;
   localparam logic [8:0]  TEMP_HYST     = 9'h001;

   // =========================================================
   // Register offsets
   localparam logic [7:0] OFF_CTRL       = 8'h00;
   localparam logic [7:0] OFF_TLIMIT     = 8'h04;
   localparam logic [7:0] OFF_SHORT_LIM  = 8'h08;
   localparam logic [7:0] OFF_DIE_TEMP   = 8'h0C;
   localparam logic [7:0] OFF_STATUS1    = 8'h10;
   localparam logic [7:0] OFF_STATUS2    = 8'h14;
   localparam logic [7:0] OFF_CHAN_STATE = 8'h18;

   // =========================================================
   // Field positions and reset values
   localparam int unsigned CTRL_TEMP_EN  = 0;
   localparam int unsigned CTRL_LED_IE   = 1;
   localparam int unsigned CTRL_EXCL_LSB = 8;
   localparam int unsigned TLIM_HI_LSB   = 0;
   localparam int unsigned TLIM_LO_LSB   = 16;
   localparam int unsigned S1_OVP_LOW    = 0;
   localparam int unsigned S1_OVP_HIGH   = 1;
   localparam int unsigned S1_BOOST_OCP  = 2;
   localparam int unsigned S1_VIN_UVLO   = 3;
   localparam int unsigned S1_VIN_OVP    = 4;
   localparam int unsigned S1_VIN_OCP    = 5;
   localparam int unsigned S1_TEMP_HIGH  = 6;
   localparam int unsigned S1_TEMP_LOW   = 7;
   localparam int unsigned S2_SUMMARY    = 0;
   localparam int unsigned S2_OPEN       = 1;
   localparam int unsigned S2_SHORT      = 2;
   localparam int unsigned S2_CH_LSB     = 8;
   localparam logic [8:0]  TLIM_HI_RST   = 9'h064;
   localparam logic [8:0]  TLIM_LO_RST   = 9'h1D8;
   localparam logic [7:0]  SHORT_LIM_RST = 8'h40;
   localparam logic        LED_IE_RST    = 1'b1;

   // =========================================================
   // Types
   typedef struct packed {
      logic [5:0] headroom_low;
      logic [5:0] headroom_short;
      logic       fb_ovp_low;
      logic       fb_ovp_high;
      logic       fb_uvp;
      logic       vin_uvlo;
      logic       vin_ovp;
      logic       vin_ocp;
   } fmtw_sense_s;

   typedef enum logic [3:0] {
      TM_OFF  = 4'b0001,
      TM_WARM = 4'b0010,
      TM_CONV = 4'b0100,
      TM_WAIT = 4'b1000
   } fmtw_tm_e;
endpackage
`default_nettype wire

// File: rtl/fmtw_sync.sv
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Inputs are asynchronous comparator levels.
// Notes:   Output changes only once stages two and three agree.
`default_nettype none
module fmtw_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Data
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // =========================================================
   // Per-bit synchroniser
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               s1_reg[i]   <= 1'b0;
               s2_reg[i]   <= 1'b0;
               s3_reg[i]   <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               s1_reg[i] <= async_in[i];
               s2_reg[i] <= s1_reg[i];
               s3_reg[i] <= s2_reg[i];
               if (s2_reg[i] == s3_reg[i]) begin
                  sync_out[i] <= s3_reg[i];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// File: rtl/fmtw_top.sv
// Purpose: Fault supervision and die temperature window monitor.
// Assumes: Comparator levels are asynchronous; mode inputs share clk.
// Notes:   Avalon-MM slave, one wait state on every access.
`default_nettype none
module fmtw_top
   import fmtw_pkg::*;
#(
   parameter int unsigned WARMUP_CYCLES    = WARMUP_CYC,
   parameter int unsigned PERIOD_CYCLES    = PERIOD_CYC,
   parameter int unsigned BOOST_OCP_CYCLES = BOOST_OCP_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   // Analog comparator levels
   input  wire fmtw_sense_s sense_async,
   // Temperature converter
   input  wire logic        adc_done,
   input  wire logic [8:0]  adc_result,
   output var  logic        adc_start,
   output var  logic        temp_mon_power,
   // Device mode from the sequencer
   input  wire logic        device_active,
   input  wire logic        boost_running,
   input  wire logic        pl_softstart,
   input  wire logic        boost_at_max,
   // Control outputs
   output var  logic        boost_step_up,
   output var  logic        boost_switch_inhibit,
   output var  logic        fault_recovery,
   output var  logic        standby_req,
   output var  logic        startup_req,
   output var  logic [5:0]  channel_enable,
   output var  logic [7:0]  short_headroom_limit,
   output var  logic        fault_irq
);
   // =========================================================
   // Input synchronisers
   fmtw_sense_s sense;
   fmtw_sense_s sense_prev_reg;

   fmtw_sync #(.W($bits(fmtw_sense_s))) u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in (sense_async),
      .sync_out (sense)
   );

   // =========================================================
   // Register bus
   logic [31:0] ctrl_reg;
   logic [31:0] tlimit_reg;
   logic [7:0]  status1_reg;
   logic [7:0]  status1_next;
   logic        summary_reg;
   logic        summary_next;
   logic        open_cause_reg;
   logic        short_cause_reg;
   logic [5:0]  ch_fault_reg;
   logic [8:0]  die_temp_reg;

   // Byte lanes mask both stored fields and write-one-to-clear data
   wire         req     = read | write;
   wire         wr_fire = write & ~waitrequest;
   wire [31:0]  wmask   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                           {8{byteenable[1]}}, {8{byteenable[0]}}};
   wire [31:0]  wdm     = writedata & wmask;
   wire         sel_ctrl  = (address == OFF_CTRL);
   wire         sel_tlim  = (address == OFF_TLIMIT);
   wire         sel_short = (address == OFF_SHORT_LIM);
   wire         sel_s1    = (address == OFF_STATUS1);
   wire         sel_s2    = (address == OFF_STATUS2);
   wire [31:0]  status2_word = {18'h00000, ch_fault_reg, 5'h00,
                                short_cause_reg, open_cause_reg,
                                summary_reg};
   wire [31:0]  rd_mux =
      sel_ctrl  ? ctrl_reg :
      sel_tlim  ? tlimit_reg :
      sel_short ? {24'h000000, short_headroom_limit} :
      (address == OFF_DIE_TEMP)   ? {23'h000000, die_temp_reg} :
      sel_s1    ? {24'h000000, status1_reg} :
      sel_s2    ? status2_word :
      (address == OFF_CHAN_STATE) ? {26'h0000000, channel_enable} :
      32'h00000000;

   wire         temp_en  = ctrl_reg[CTRL_TEMP_EN];
   wire         led_ie   = ctrl_reg[CTRL_LED_IE];
   wire [5:0]   loop_excl = ctrl_reg[CTRL_EXCL_LSB +: NCH];
   // Defaults come with reset only, so a write of all zeros stays put
   localparam logic [31:0] CTRL_RST = {18'h00000, 12'h000, LED_IE_RST, 1'b0};
   localparam logic [31:0] TLIM_RST = {7'h00, TLIM_LO_RST, 7'h00, TLIM_HI_RST};

   // One wait state: the request is seen, then answered a cycle later
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h00000000;
      end else begin
         waitrequest <= ~(req & waitrequest);
         if (read & waitrequest) begin
            readdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_reg             <= CTRL_RST;
         tlimit_reg           <= TLIM_RST;
         short_headroom_limit <= SHORT_LIM_RST;
      end else if (wr_fire) begin
         if (sel_ctrl) begin
            ctrl_reg <= ((ctrl_reg & ~wmask) | wdm) & 32'h00003F03;
         end
         if (sel_tlim) begin
            tlimit_reg <= ((tlimit_reg & ~wmask) | wdm) & 32'h01FF01FF;
         end
         if (sel_short && byteenable[0]) begin
            short_headroom_limit <= writedata[7:0];
         end
      end
   end

   // =========================================================
   // Temperature monitor sequencer
   fmtw_tm_e        tm_reg;
   logic [TMR_W-1:0] tm_cnt_reg;
   wire [TMR_W-1:0] warm_last = TMR_W'(WARMUP_CYCLES - 1);
   wire [TMR_W-1:0] per_last  = TMR_W'(PERIOD_CYCLES - 1);
   wire             tm_hit    = (tm_reg == TM_WARM) ?
                                (tm_cnt_reg == warm_last) :
                                (tm_cnt_reg == per_last);

   // Counter keeps running through conversion so the 10 Hz grid holds
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tm_reg         <= TM_OFF;
         tm_cnt_reg     <= '0;
         adc_start      <= 1'b0;
         temp_mon_power <= 1'b0;
         die_temp_reg   <= TEMP_OFF_VAL;
      end else begin
         adc_start      <= 1'b0;
         temp_mon_power <= temp_en;
         tm_cnt_reg     <= (tm_hit || tm_reg == TM_OFF) ?
                           '0 : tm_cnt_reg + 1'b1;
         if (!temp_en) begin
            tm_reg       <= TM_OFF;
            die_temp_reg <= TEMP_OFF_VAL;
         end else begin
            unique case (tm_reg)
               TM_OFF: begin
                  tm_reg <= TM_WARM;
               end
               TM_WARM: begin
                  if (tm_hit) begin
                     tm_reg    <= TM_CONV;
                     adc_start <= 1'b1;
                  end
               end
               TM_CONV: begin
                  if (adc_done) begin
                     die_temp_reg <= adc_result;
                     tm_reg       <= TM_WAIT;
                  end
               end
               TM_WAIT: begin
                  if (tm_hit) begin
                     tm_reg    <= TM_CONV;
                     adc_start <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // =========================================================
   // Thermal window with hysteresis
   logic        above_hi_reg;
   logic        below_lo_reg;
   logic        valid_temp_reg;
   wire  signed [9:0] t_s   = {die_temp_reg[8], die_temp_reg};
   wire  signed [9:0] hi_s  = {tlimit_reg[TLIM_HI_LSB + 8],
                               tlimit_reg[TLIM_HI_LSB +: TEMP_W]};
   wire  signed [9:0] lo_s  = {tlimit_reg[TLIM_LO_LSB + 8],
                               tlimit_reg[TLIM_LO_LSB +: TEMP_W]};
   wire  signed [9:0] hyst  = {1'b0, TEMP_HYST};
   wire         hi_set  = t_s >= (hi_s + hyst);
   wire         hi_clr  = t_s <= (hi_s - hyst);
   wire         lo_set  = t_s <= (lo_s - hyst);
   wire         lo_clr  = t_s >= (lo_s + hyst);
   wire         win_on  = temp_en & valid_temp_reg;
   wire         hi_next = win_on & (hi_set | (above_hi_reg & ~hi_clr));
   wire         lo_next = win_on & (lo_set | (below_lo_reg & ~lo_clr));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         above_hi_reg   <= 1'b0;
         below_lo_reg   <= 1'b0;
         valid_temp_reg <= 1'b0;
      end else begin
         valid_temp_reg <= temp_en & (valid_temp_reg |
                           (tm_reg == TM_CONV & adc_done));
         above_hi_reg   <= hi_next;
         below_lo_reg   <= lo_next;
      end
   end

   // =========================================================
   // LED open and short detection
   // Removed channels stay out of the loop until the next reset
   wire [5:0] in_loop   = channel_enable & ~loop_excl;
   wire [5:0] low_ch    = sense.headroom_low & in_loop;
   wire [5:0] short_ch  = sense.headroom_short & in_loop;
   wire [5:0] normal_ch = in_loop & ~sense.headroom_low &
                          ~sense.headroom_short;
   wire       open_ev   = boost_running & boost_at_max & (|low_ch);
   wire       short_ev  = boost_running & (|short_ch) & (|normal_ch);
   wire [5:0] open_hit  = open_ev  ? low_ch   : 6'h00;
   wire [5:0] short_hit = short_ev ? short_ch : 6'h00;
   wire       led_ev    = open_ev | short_ev;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         channel_enable  <= 6'h3F;
         boost_step_up   <= 1'b0;
         open_cause_reg  <= 1'b0;
         short_cause_reg <= 1'b0;
         ch_fault_reg    <= 6'h00;
         summary_reg     <= 1'b0;
      end else begin
         boost_step_up   <= boost_running & ~boost_at_max &
                            (|low_ch);
         channel_enable  <= channel_enable & ~open_hit & ~short_hit;
         open_cause_reg  <= open_cause_reg | open_ev;
         short_cause_reg <= short_cause_reg | short_ev;
         ch_fault_reg    <= ch_fault_reg | open_hit | short_hit;
         summary_reg     <= summary_next;
      end
   end

   // Set wins over a clear arriving in the same cycle
   wire summary_clr = wr_fire & sel_s2 & wdm[S2_SUMMARY];
   assign summary_next = (summary_reg & ~summary_clr) | led_ev;

   // =========================================================
   // Boost and power-line faults
   logic [TMR_W-1:0]  uvp_cnt_reg;
   logic [VOCP_W-1:0] vocp_cnt_reg;
   logic              standby_prev_reg;
   wire [TMR_W-1:0]   uvp_last  = TMR_W'(BOOST_OCP_CYCLES);
   wire [VOCP_W-1:0]  vocp_last = VOCP_W'(VIN_OCP_CYC - 1);
   // Timers restart whenever their condition drops for a single cycle
   wire  uvp_watch  = boost_running & sense.fb_uvp;
   wire  boost_ocp  = uvp_watch & (uvp_cnt_reg == uvp_last);
   wire  vocp_watch = pl_softstart & sense.vin_ocp;
   wire  vin_ocp_ev = vocp_watch & (vocp_cnt_reg == vocp_last);
   wire  ovph_ev    = device_active & sense.fb_ovp_high &
                      ~sense_prev_reg.fb_ovp_high;
   wire  ovpl_on    = device_active & sense.fb_ovp_low;
   wire  uvlo_ev    = sense.vin_uvlo & ~sense_prev_reg.vin_uvlo;
   wire  ovp_ev     = sense.vin_ovp & ~sense_prev_reg.vin_ovp;
   wire  in_standby = sense.vin_uvlo | sense.vin_ovp;
   wire  thi_ev     = hi_next & ~above_hi_reg;
   wire  tlo_ev     = lo_next & ~below_lo_reg;

   wire [7:0] s1_set;
   assign s1_set[S1_OVP_LOW]   = ovpl_on;
   assign s1_set[S1_OVP_HIGH]  = ovph_ev;
   assign s1_set[S1_BOOST_OCP] = boost_ocp;
   assign s1_set[S1_VIN_UVLO]  = uvlo_ev;
   assign s1_set[S1_VIN_OVP]   = ovp_ev;
   assign s1_set[S1_VIN_OCP]   = vin_ocp_ev;
   assign s1_set[S1_TEMP_HIGH] = thi_ev;
   assign s1_set[S1_TEMP_LOW]  = tlo_ev;
   wire [7:0] s1_clr = (wr_fire & sel_s1) ? wdm[7:0] : 8'h00;
   assign status1_next = (status1_reg & ~s1_clr) | s1_set;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sense_prev_reg       <= '0;
         uvp_cnt_reg          <= '0;
         vocp_cnt_reg         <= '0;
         standby_prev_reg     <= 1'b0;
         status1_reg          <= 8'h00;
         boost_switch_inhibit <= 1'b0;
         fault_recovery       <= 1'b0;
         standby_req          <= 1'b0;
         startup_req          <= 1'b0;
         fault_irq            <= 1'b0;
      end else begin
         sense_prev_reg       <= sense;
         uvp_cnt_reg          <= (uvp_watch && !boost_ocp) ?
                                 uvp_cnt_reg + 1'b1 : '0;
         vocp_cnt_reg         <= (vocp_watch && !vin_ocp_ev) ?
                                 vocp_cnt_reg + 1'b1 : '0;
         standby_prev_reg     <= in_standby;
         status1_reg          <= status1_next;
         boost_switch_inhibit <= ovpl_on;
         fault_recovery       <= ovph_ev | boost_ocp | vin_ocp_ev;
         standby_req          <= in_standby;
         startup_req          <= standby_prev_reg & ~in_standby;
         fault_irq            <= (|status1_next) |
                                 (summary_next & led_ie);
      end
   end
endmodule
`default_nettype wire

// File: tb/fmtw_adc_model.sv
// Purpose: Behavioural temperature converter beside the monitor.
// Assumes: One conversion per adc_start, result after four clocks.
// Notes:   Result lines hold garbage outside the done cycle.
`default_nettype none
module fmtw_adc_model (
   // Clock and control
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       adc_start,
   input  wire logic       temp_mon_power,
   // Temperature seen by the sensor, and result
   input  wire logic [8:0] temp_in,
   output var  logic       adc_done,
   output var  logic [8:0] adc_result
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_reg    <= 3'h0;
         adc_done   <= 1'b0;
         adc_result <= 9'h000;
      end else begin
         adc_done <= (cnt_reg == 3'h1) && temp_mon_power;
         cnt_reg  <= adc_start ? 3'h4 : cnt_reg - (cnt_reg != 3'h0);
         // Inverted data outside done so a stale value is never read
         adc_result <= (cnt_reg == 3'h1) ? temp_in : ~adc_result;
      end
   end
endmodule
`default_nettype wire

// File: tb/fmtw_top_sva.sv
// Purpose: Port-level checks of the fault and thermal monitor.
// Assumes: All ports in the clk domain.
// Notes:   Bound to every instance of the top module.
`default_nettype none
module fmtw_top_sva
   import fmtw_pkg::*;
(
   // Clock, reset and bus
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       read,
   input  wire logic       write,
   input  wire logic       waitrequest,
   // Mode and control
   input  wire logic       adc_start,
   input  wire logic       temp_mon_power,
   input  wire logic       device_active,
   input  wire logic       boost_at_max,
   input  wire logic       boost_step_up,
   input  wire logic       boost_switch_inhibit,
   input  wire logic       fault_recovery,
   input  wire logic       standby_req,
   input  wire logic       startup_req,
   input  wire logic [5:0] channel_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // =====
   // Assertions
   AST_WAIT_ANSWER: assert property ((read | write) && waitrequest
      |=> !waitrequest) else $error("access not answered in one cycle");
   AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
   AST_ADC_OFF: assert property (!temp_mon_power &&
      !$past(temp_mon_power) |-> !adc_start)
      else $error("conversion started while powered down");
   AST_STEP_MAX: assert property (boost_step_up |->
      !$past(boost_at_max)) else $error("step up at maximum boost");
   AST_INHIBIT: assert property (boost_switch_inhibit |->
      $past(device_active)) else $error("inhibit outside active");
   AST_CHAN_STICKY: assert property (
      (channel_enable & ~$past(channel_enable)) == 6'h00)
      else $error("removed channel came back");
   AST_RECOV_PULSE: assert property ($rose(fault_recovery)
      |=> !fault_recovery) else $error("recovery pulse too long");
   AST_STARTUP: assert property (startup_req |-> !standby_req)
      else $error("startup during standby");
   AST_RESTART: assert property ($fell(standby_req)
      |-> ##[0:2] startup_req) else $error("no startup after standby");
   // =====
   // Coverage
   COV_RECOV: cover property (fault_recovery);
   COV_START: cover property (startup_req);
   COV_ADC: cover property (adc_start);
endmodule
bind fmtw_top fmtw_top_sva SVA (.*);
`default_nettype wire

// File: tb/test_fault_monitor_thermal_window.sv
// Purpose: Register-level test of the fault and thermal monitor.
// Assumes: Shortened warm-up, period and boost overcurrent counts.
// Notes:   Outputs are read just after an edge, before its updates.
`default_nettype none
module test_fault_monitor_thermal_window
   import fmtw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, read, write, waitrequest, adc_start, adc_done;
   logic temp_mon_power, device_active, boost_running, pl_softstart;
   logic boost_at_max, boost_step_up, boost_switch_inhibit, fault_irq;
   logic fault_recovery, standby_req, startup_req;
   logic [7:0] address, short_headroom_limit;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, d;
   logic [8:0] adc_result, temp;
   logic [5:0] channel_enable;
   fmtw_sense_s sense;
   int n_fail, checked, n_rec, n_start, n;
   logic [7:0] ra [8] = '{OFF_CTRL, OFF_TLIMIT, OFF_SHORT_LIM,
      OFF_DIE_TEMP, OFF_STATUS1, OFF_STATUS2, OFF_CHAN_STATE, 8'h1C};
   logic [31:0] rv [8] = '{32'h2, 32'h01D80064, 32'h40, 32'h100,
      32'h0, 32'h0, 32'h3F, 32'h0};
   fmtw_top #(.WARMUP_CYCLES(20), .PERIOD_CYCLES(50),
      .BOOST_OCP_CYCLES(30)) DUT (.*, .sense_async(sense));
   fmtw_adc_model ADC (.clk(clk), .reset(reset), .adc_start(adc_start),
      .temp_mon_power(temp_mon_power), .temp_in(temp),
      .adc_done(adc_done), .adc_result(adc_result));
   // =====
   // Tasks
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      // Idle edge first, so a release and a new request never share a step
      @(posedge clk);
      address <= a;
      writedata <= wd;
      read <= !w;
      write <= w;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(d, e);
   endtask
   task automatic wait_start();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (adc_start !== 1'b1);
   endtask
   task automatic final_report();
      $display("Checks %0d, errors %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // =====
   // Clock, monitors, watchdog
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      n_rec += (fault_recovery === 1'b1);
      n_start += (startup_req === 1'b1);
   end
   initial begin
      cyc(20000);
      n_fail++;
      final_report();
   end
   // =====
   // Tests
   initial begin
      {reset, read, write, device_active, boost_running} = 5'h10;
      {pl_softstart, boost_at_max, address, writedata} = '0;
      {byteenable, sense, temp} = {4'hF, 18'h0, 9'h019};
      {n_fail, checked, n_rec, n_start} = '0;
      cyc(4);
      reset <= 1'b0;
      cyc(2);
      for (int i = 0; i < 8; i++) rchk(ra[i], rv[i]);
      bus(1'b1, OFF_CTRL, 32'h3);
      wait_start();
      wait_start();
      chk(n, 50);
      cyc(10);
      rchk(OFF_DIE_TEMP, 32'h019);
      temp <= 9'h065;
      wait_start();
      cyc(10);
      rchk(OFF_STATUS1, 32'h40);
      chk(fault_irq, 1);
      bus(1'b1, OFF_STATUS1, 32'hFF);
      temp <= 9'h064;
      wait_start();
      cyc(10);
      rchk(OFF_STATUS1, 32'h0);
      chk(fault_irq, 0);
      temp <= 9'h1D7;
      wait_start();
      cyc(10);
      rchk(OFF_STATUS1, 32'h80);
      bus(1'b1, OFF_CTRL, 32'h2);
      cyc(4);
      rchk(OFF_DIE_TEMP, 32'h100);
      chk(temp_mon_power, 0);
      bus(1'b1, OFF_STATUS1, 32'hFF);
      device_active <= 1'b1;
      sense.fb_ovp_low <= 1'b1;
      cyc(8);
      chk(boost_switch_inhibit, 1);
      bus(1'b1, OFF_STATUS1, 32'hFF);
      rchk(OFF_STATUS1, 32'h1);
      sense.fb_ovp_low <= 1'b0;
      sense.fb_ovp_high <= 1'b1;
      cyc(8);
      chk(boost_switch_inhibit, 0);
      bus(1'b1, OFF_STATUS1, 32'h1);
      rchk(OFF_STATUS1, 32'h2);
      chk({fault_irq, n_rec[3:0]}, 5'h11);
      {device_active, boost_running, sense.fb_ovp_high} <= 3'h2;
      sense.fb_uvp <= 1'b1;
      bus(1'b1, OFF_STATUS1, 32'hFF);
      cyc(18);
      sense.fb_uvp <= 1'b0;
      cyc(6);
      rchk(OFF_STATUS1, 32'h0);
      sense.fb_uvp <= 1'b1;
      cyc(40);
      rchk(OFF_STATUS1, 32'h4);
      chk(n_rec, 2);
      sense.fb_uvp <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         {sense.vin_ovp, sense.vin_uvlo} <= 2'h1 << i;
         cyc(8);
         chk(standby_req, 1);
         rchk(OFF_STATUS1, (i == 0) ? 32'hC : 32'h10);
         {sense.vin_ovp, sense.vin_uvlo} <= 2'h0;
         bus(1'b1, OFF_STATUS1, 32'hFF);
         cyc(8);
         chk({standby_req, n_start[3:0]}, i + 1);
      end
      sense.vin_ocp <= 1'b1;
      cyc(1300);
      rchk(OFF_STATUS1, 32'h0);
      pl_softstart <= 1'b1;
      cyc(1000);
      rchk(OFF_STATUS1, 32'h0);
      cyc(300);
      rchk(OFF_STATUS1, 32'h20);
      chk(n_rec, 3);
      {sense.vin_ocp, pl_softstart} <= 2'h0;
      sense.headroom_low <= 6'h04;
      bus(1'b1, OFF_STATUS1, 32'hFF);
      cyc(8);
      chk(boost_step_up, 1);
      boost_at_max <= 1'b1;
      cyc(8);
      chk(channel_enable, 6'h3B);
      rchk(OFF_STATUS2, 32'h0403);
      chk(fault_irq, 1);
      bus(1'b1, OFF_STATUS2, 32'h1);
      rchk(OFF_STATUS2, 32'h0402);
      chk(fault_irq, 0);
      {sense.headroom_low, boost_at_max} <= 7'h0;
      bus(1'b1, OFF_CTRL, 32'h0);
      sense.headroom_short <= 6'h10;
      cyc(8);
      rchk(OFF_STATUS2, 32'h1407);
      chk(fault_irq, 0);
      bus(1'b1, OFF_CTRL, 32'h2);
      cyc(3);
      chk(fault_irq, 1);
      rchk(OFF_CHAN_STATE, 32'h2B);
      chk(short_headroom_limit, 8'h40);
      bus(1'b1, OFF_SHORT_LIM, 32'h30);
      cyc(3);
      chk(short_headroom_limit, 8'h30);
      bus(1'b1, OFF_CTRL, 32'h0102);
      rchk(OFF_CTRL, 32'h0102);
      sense.headroom_low <= 6'h01;
      cyc(8);
      chk(boost_step_up, 0);
      boost_at_max <= 1'b1;
      cyc(8);
      rchk(OFF_CHAN_STATE, 32'h2B);
      bus(1'b1, OFF_CTRL, 32'h2);
      cyc(8);
      rchk(OFF_CHAN_STATE, 32'h2A);
      final_report();
   end
endmodule
`default_nettype wire
